// file: verilog/sclk_pkg.sv
// Package: constants, modes and carriers for the sample clock routing block
package sclk_pkg;

  // Base clock and divider limits
  localparam int unsigned BASE_CLOCK_HZ   = 200_000_000;
  localparam int unsigned DIV_MIN         = 2;
  localparam int unsigned DIV_MAX         = 4_194_304;
  localparam int          DIV_W           = 23;
  localparam logic [DIV_W-1:0] DIV_RESET  = 23'h000002;

  // Phase adjust: 10 ps steps over one period
  localparam int          PHASE_STEP_PS   = 10;
  localparam int          PHASE_W         = 27;

  // Fractional delays in 1/256 period steps
  localparam int          FRAC_W          = 8;
  localparam logic [FRAC_W-1:0] FRAC_RESET = 8'h00;

  // Rate thresholds for delay validity
  localparam int unsigned EXPORT_DELAY_MIN_HZ = 2_500_000;
  localparam int unsigned DATA_DELAY_MIN_HZ   = 25_000_000;
  localparam int unsigned MAX_RATE_HZ         = 100_000_000;

  // Export offset choices, in picoseconds
  localparam int          OFFSET_SMALL_PS = 0;
  localparam int          OFFSET_LARGE_PS = 2500;
  localparam logic        OFFSET_RESET    = 1'b1;

  // Reference clock and lock time
  localparam int unsigned REF_HZ          = 10_000_000;
  localparam int unsigned LOCK_TIME_MS    = 400;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned LOCK_CYCLES     = LOCK_TIME_MS * (CLK_HZ / 1000);

  localparam int          NUM_CHANNELS    = 20;

  // Sample clock source
  typedef enum logic [1:0] {
    SRC_ONBOARD,
    SRC_EXT_IN,
    SRC_STROBE
  } src_e;

  // Phase locked loop reference
  typedef enum logic [1:0] {
    REF_NONE,
    REF_TRIGGER_BUS,
    REF_EXT_IN
  } ref_e;

  // Data launch or capture edge
  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_DELAY
  } edge_e;

  // Coaxial output selection
  typedef enum logic {
    COAX_SAMPLE,
    COAX_REFERENCE
  } coax_e;

  // Clock configuration carrier
  typedef struct packed {
    src_e              src;
    ref_e              pll_ref;
    coax_e             coax;
    logic              acquiring;
    logic              offset_large;
    logic [DIV_W-1:0]  divisor;
    logic [PHASE_W-1:0] phase;
    logic [FRAC_W-1:0] export_delay;
    edge_e             gen_edge;
    logic [FRAC_W-1:0] gen_delay;
  } clk_cfg_s;

endpackage : sclk_pkg

// file: verilog/sample_clock_routing.sv
// Sample clock selection, division, delay and export logic
`timescale 1ns/1ps

module sample_clock_routing
  import sclk_pkg::*;
#(
  parameter int NCH         = NUM_CHANNELS,
  parameter int LOCK_CYCLES_P = LOCK_CYCLES
) (
  input  wire logic                   CLK,
  input  wire logic                   RSTN,
  input  wire clk_cfg_s               CFG,
  input  wire logic [2*NCH-1:0]       CAP_EDGE,
  input  wire logic [NCH*FRAC_W-1:0]  CAP_DELAY,
  input  wire logic                   EXT_CLK_IN,
  input  wire logic                   STROBE_IN,
  input  wire logic                   TRIGGER_BUS_LINE_SEVEN,
  input  wire logic [NCH-1:0]         GEN_DATA,
  input  wire logic [NCH-1:0]         GEN_DRIVE_EN,
  input  wire logic                   GEN_SAMPLE_VALID,
  input  wire logic [NCH-1:0]         CAP_PIN,
  output logic                        SAMPLE_TICK,
  output logic                        SAMPLE_CLK,
  output logic                        CABLE_CLOCK_OUTPUT,
  output logic                        COAX_CLOCK_OUTPUT,
  output logic                        PLL_REF_CLK,
  output logic                        PLL_LOCKED,
  output logic                        SRC_ERROR,
  output logic [PHASE_W-1:0]          PHASE_ADJ,
  output logic [FRAC_W-1:0]           EXPORT_DELAY,
  output logic                        EXPORT_OFFSET_LARGE,
  output logic [FRAC_W-1:0]           GEN_DATA_DELAY,
  output edge_e                       GEN_LAUNCH_EDGE,
  output logic [NCH-1:0]              DATA_OUT,
  output logic [NCH-1:0]              DATA_OE,
  output logic [NCH-1:0]              CAP_DATA,
  output logic                        CAP_VALID
);

  ////////////////////////////////////////////////////////////////////////////
  // Local state

  logic [DIV_W-1:0]   div_cnt_ff;
  logic               onboard_clk_ff;
  logic               onboard_tick;
  logic [DIV_W-1:0]   div_eff;
  logic               ext_d_ff;
  logic               strobe_d_ff;
  logic               ext_rise;
  logic               strobe_rise;
  logic               src_ok;
  src_e               src_eff;
  logic               sample_lvl;
  logic               sample_pulse;
  logic               ref_lvl;
  logic [31:0]        lock_cnt_ff;
  ref_e               ref_prev_ff;
  logic [DIV_W:0]     half_div;
  logic               rate_ge_export;
  logic               rate_ge_data;

  // Clamp divisor up to DIV_MIN; there is no clamp at DIV_MAX
  always_comb begin
    if (CFG.divisor < DIV_W'(DIV_MIN)) begin
      div_eff = DIV_W'(DIV_MIN);
    end else begin
      div_eff = CFG.divisor;
    end
  end
  // Half period point sets the onboard duty cycle
  assign half_div = {1'b0, div_eff} >> 1;

  ////////////////////////////////////////////////////////////////////////////
  // Onboard divider; CLK stands in for the base, tick once per divisor

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt_ff     <= '0;
      onboard_clk_ff <= 1'b0;
    end else begin
      if (div_cnt_ff >= div_eff - DIV_W'(1)) begin
        div_cnt_ff <= '0;
      end else begin
        div_cnt_ff <= div_cnt_ff + DIV_W'(1);
      end
      onboard_clk_ff <= ({1'b0, div_cnt_ff} < half_div);
    end
  end
  // One sample per divider wrap
  assign onboard_tick = (div_cnt_ff == '0);

  // Rate comparisons from the divisor
  assign rate_ge_export = (div_eff <= DIV_W'(BASE_CLOCK_HZ
                                     / EXPORT_DELAY_MIN_HZ));
  assign rate_ge_data   = (div_eff <= DIV_W'(BASE_CLOCK_HZ
                                     / DATA_DELAY_MIN_HZ));

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect of external and strobe inputs

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_d_ff    <= 1'b0;
      strobe_d_ff <= 1'b0;
    end else begin
      ext_d_ff    <= EXT_CLK_IN;
      strobe_d_ff <= STROBE_IN;
    end
  end
  assign ext_rise    = EXT_CLK_IN & ~ext_d_ff;
  assign strobe_rise = STROBE_IN & ~strobe_d_ff;

  // Source select; strobe only while acquiring, external only if not ref
  always_comb begin
    src_ok = 1'b1;
    src_eff = CFG.src;
    if (CFG.src == SRC_STROBE && !CFG.acquiring) begin
      src_ok  = 1'b0;
      src_eff = SRC_ONBOARD;
    end else if (CFG.src == SRC_EXT_IN && CFG.pll_ref == REF_EXT_IN) begin
      src_ok  = 1'b0;
      src_eff = SRC_ONBOARD;
    end else if (CFG.src != SRC_ONBOARD && CFG.src != SRC_EXT_IN
                 && CFG.src != SRC_STROBE) begin
      src_ok  = 1'b0;
      src_eff = SRC_ONBOARD;
    end
  end

  always_comb begin
    case (src_eff)
      SRC_EXT_IN: begin
        sample_lvl   = EXT_CLK_IN;
        sample_pulse = ext_rise;
      end
      SRC_STROBE: begin
        sample_lvl   = STROBE_IN;
        sample_pulse = strobe_rise;
      end
      default: begin
        sample_lvl   = onboard_clk_ff;
        sample_pulse = onboard_tick;
      end
    endcase
  end

  // Reference select for the phase locked loop
  always_comb begin
    case (CFG.pll_ref)
      REF_TRIGGER_BUS: ref_lvl = TRIGGER_BUS_LINE_SEVEN;
      REF_EXT_IN:      ref_lvl = EXT_CLK_IN;
      default:         ref_lvl = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock outputs

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SAMPLE_TICK        <= 1'b0;
      SAMPLE_CLK         <= 1'b0;
      CABLE_CLOCK_OUTPUT <= 1'b0;
      COAX_CLOCK_OUTPUT  <= 1'b0;
      PLL_REF_CLK        <= 1'b0;
      SRC_ERROR          <= 1'b0;
    end else begin
      SAMPLE_TICK <= sample_pulse;
      SAMPLE_CLK  <= sample_lvl;
      SRC_ERROR   <= ~src_ok;
      PLL_REF_CLK <= ref_lvl;
      // Strobe sourced clocks are held low on exports
      CABLE_CLOCK_OUTPUT <= (src_eff != SRC_STROBE) & sample_lvl;
      if (CFG.coax == COAX_REFERENCE) begin
        COAX_CLOCK_OUTPUT <= ref_lvl;
      end else begin
        COAX_CLOCK_OUTPUT <= (src_eff != SRC_STROBE) & sample_lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock timer, restarts on each reference change

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_cnt_ff <= '0;
      ref_prev_ff <= REF_NONE;
      PLL_LOCKED  <= 1'b0;
    end else begin
      ref_prev_ff <= CFG.pll_ref;
      if (CFG.pll_ref == REF_NONE || CFG.pll_ref != ref_prev_ff) begin
        lock_cnt_ff <= '0;
        PLL_LOCKED  <= 1'b0;
      end else if (lock_cnt_ff >= 32'(LOCK_CYCLES_P - 1)) begin
        PLL_LOCKED  <= 1'b1;
      end else begin
        lock_cnt_ff <= lock_cnt_ff + 32'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay and offset settings, fine delays gated by rate for the onboard source

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PHASE_ADJ           <= '0;
      EXPORT_DELAY        <= FRAC_RESET;
      GEN_DATA_DELAY      <= FRAC_RESET;
      GEN_LAUNCH_EDGE     <= EDGE_RISE;
      EXPORT_OFFSET_LARGE <= OFFSET_RESET;
    end else begin
      PHASE_ADJ           <= CFG.phase;
      EXPORT_DELAY        <= rate_ge_export || src_eff != SRC_ONBOARD
                             ? CFG.export_delay : FRAC_RESET;
      EXPORT_OFFSET_LARGE <= CFG.offset_large;
      GEN_LAUNCH_EDGE     <= CFG.gen_edge;
      GEN_DATA_DELAY      <= rate_ge_data || src_eff != SRC_ONBOARD
                             ? CFG.gen_delay : FRAC_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generation: data held between ticks, per sample driver enable

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_OUT <= '0;
      DATA_OE  <= '0;
    end else if (sample_pulse && GEN_SAMPLE_VALID) begin
      DATA_OUT <= GEN_DATA;
      DATA_OE  <= GEN_DRIVE_EN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition: per channel edge choice

  logic [NCH-1:0] cap_nxt;
  logic [NCH-1:0] cap_hit;
  logic           fall_pulse;
  logic           sample_d_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sample_d_ff <= 1'b0;
    end else begin
      sample_d_ff <= sample_lvl;
    end
  end
  // Falling edge of the selected clock
  assign fall_pulse = ~sample_lvl & sample_d_ff;

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_cap
      edge_e sel;
      assign sel = edge_e'(CAP_EDGE[2*i +: 2]);
      // Delayed capture uses rising edge here; fine delay is analog
      always_comb begin
        case (sel)
          EDGE_FALL: cap_hit[i] = fall_pulse;
          default:   cap_hit[i] = sample_pulse;
        endcase
        cap_nxt[i] = cap_hit[i] ? CAP_PIN[i] : CAP_DATA[i];
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CAP_DATA  <= '0;
      CAP_VALID <= 1'b0;
    end else begin
      CAP_DATA  <= cap_nxt;
      CAP_VALID <= CFG.acquiring & sample_pulse;
    end
  end

  // Capture delay per channel is not used; it only feeds the unused_cap_delay reduction
  logic unused_cap_delay;
  assign unused_cap_delay = ^CAP_DELAY;

endmodule : sample_clock_routing

// file: test/sample_clock_routing_properties.sv
// Checker for the sample clock routing block
`timescale 1ns/1ps
module sample_clock_routing_properties
  import sclk_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
) (
  input wire logic           CLK,
  input wire logic           RSTN,
  input wire clk_cfg_s       CFG,
  input wire logic           SAMPLE_TICK,
  input wire logic           CABLE_CLOCK_OUTPUT,
  input wire logic           COAX_CLOCK_OUTPUT,
  input wire logic           PLL_LOCKED,
  input wire logic           SRC_ERROR,
  input wire logic           EXPORT_OFFSET_LARGE,
  input wire logic [7:0]     EXPORT_DELAY,
  input wire logic [7:0]     GEN_DATA_DELAY,
  input wire logic [NCH-1:0] DATA_OUT,
  input wire logic [NCH-1:0] DATA_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////
  // Source legality, divide by two and export
  property p_src_err;
    CFG.src == SRC_STROBE && !CFG.acquiring |=> SRC_ERROR;
  endproperty
  a_src_err: assert property (p_src_err)
    else $error("strobe source not flagged");
  property p_no_strobe_out;
    (CFG.src == SRC_STROBE && CFG.acquiring)[*2] |-> !CABLE_CLOCK_OUTPUT;
  endproperty
  a_no_strobe_out: assert property (p_no_strobe_out)
    else $error("strobe clock exported");
  property p_div2;
    (CFG.src == SRC_ONBOARD && CFG.divisor == 23'h000002)[*4]
      |-> SAMPLE_TICK != $past(SAMPLE_TICK);
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by two not alternating");
  property p_offset;
    $changed(CFG.offset_large)
      |=> EXPORT_OFFSET_LARGE == $past(CFG.offset_large);
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset select not followed");
  ////////////////////////////////////////////////////////////////////////
  // Rate gating of fine delays
  property p_exp_gate;
    CFG.src == SRC_ONBOARD && CFG.divisor > 23'h000050
      |=> EXPORT_DELAY == 8'h00;
  endproperty
  a_exp_gate: assert property (p_exp_gate)
    else $error("export delay below rate limit");
  property p_gen_gate;
    CFG.src == SRC_ONBOARD && CFG.divisor > 23'h000008
      |=> GEN_DATA_DELAY == 8'h00;
  endproperty
  a_gen_gate: assert property (p_gen_gate)
    else $error("data delay below rate limit");
  ////////////////////////////////////////////////////////////////////////
  // Data held between samples
  property p_nrz;
    $changed(DATA_OUT) |-> SAMPLE_TICK;
  endproperty
  a_nrz: assert property (p_nrz)
    else $error("data changed between samples");
  property p_oe_cycle;
    $changed(DATA_OE) |-> SAMPLE_TICK;
  endproperty
  a_oe_cycle: assert property (p_oe_cycle)
    else $error("enable changed between samples");
  ////////////////////////////////////////////////////////////////////////
  // Reference and lock
  property p_no_lock;
    (CFG.pll_ref == REF_NONE)[*2] |=> !PLL_LOCKED;
  endproperty
  a_no_lock: assert property (p_no_lock)
    else $error("locked without reference");
  property p_coax_none;
    (CFG.coax == COAX_REFERENCE && CFG.pll_ref == REF_NONE)[*3]
      |-> !COAX_CLOCK_OUTPUT;
  endproperty
  a_coax_none: assert property (p_coax_none)
    else $error("coax drives absent reference");
  c_lock: cover property (PLL_LOCKED);
  c_err: cover property (SRC_ERROR);
  c_tick: cover property (SAMPLE_TICK ##2 SAMPLE_TICK);
endmodule : sample_clock_routing_properties

// file: test/cable_target_model.sv
// Device under test on the digital cable
`timescale 1ns/1ps
module cable_target_model
  import sclk_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
) (
  input  wire logic           CABLE_CLK,
  input  wire logic           RSTN,
  input  wire logic [NCH-1:0] DRV,
  input  wire logic [NCH-1:0] DRV_EN,
  output logic      [NCH-1:0] PIN_OUT
);
  // Echo driven lines inverted, walk a pattern on released ones
  always_ff @(posedge CABLE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PIN_OUT <= '0;
    end else begin
      PIN_OUT <= (DRV_EN & ~DRV)
               | (~DRV_EN & {PIN_OUT[NCH-2:0], ~PIN_OUT[NCH-1]});
    end
  end
endmodule : cable_target_model

// file: test/sample_clock_routing_tb.sv
// Self-checking bench for the sample clock routing block
`timescale 1ns/1ps
module sample_clock_routing_tb;
  import sclk_pkg::*;
  localparam int NCH = NUM_CHANNELS;
  localparam int LOCKN = 20;
  localparam logic [NCH-1:0] PAT = 20'hA5C3F;
  localparam logic [NCH-1:0] ENS = 20'h0F0F0;
  logic clk, rstn, gen_valid, tick, sclk, cable, coax, pref;
  logic locked, serr, off_large, cvalid;
  logic [1:0] ph = 2'h0;
  clk_cfg_s cfg;
  edge_e launch;
  logic [2*NCH-1:0] cap_edge;
  logic [NCH-1:0] gen_data, gen_en, cap_pin, dout, doe, cdata;
  logic [PHASE_W-1:0] phase_adj;
  logic [7:0] exp_dly, gen_dly;
  int error_cnt = 0;
  int n_compared = 0;
  int k, h, v, c;
  int dv[4] = '{8, 9, 80, 81};
  logic [7:0] eg[4] = '{8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0] ee[4] = '{8'h40, 8'h40, 8'h40, 8'h00};
  ////////////////////////////////////////////////////////////////////////
  sample_clock_routing #(.NCH(NCH), .LOCK_CYCLES_P(LOCKN)) dut (
    .CLK(clk), .RSTN(rstn), .CFG(cfg), .CAP_EDGE(cap_edge),
    .CAP_DELAY('0), .EXT_CLK_IN(ph[1]), .STROBE_IN(ph[1]),
    .TRIGGER_BUS_LINE_SEVEN(ph[1]), .GEN_DATA(gen_data),
    .GEN_DRIVE_EN(gen_en), .GEN_SAMPLE_VALID(gen_valid),
    .CAP_PIN(cap_pin), .SAMPLE_TICK(tick), .SAMPLE_CLK(sclk),
    .CABLE_CLOCK_OUTPUT(cable), .COAX_CLOCK_OUTPUT(coax),
    .PLL_REF_CLK(pref), .PLL_LOCKED(locked), .SRC_ERROR(serr),
    .PHASE_ADJ(phase_adj), .EXPORT_DELAY(exp_dly),
    .EXPORT_OFFSET_LARGE(off_large), .GEN_DATA_DELAY(gen_dly),
    .GEN_LAUNCH_EDGE(launch), .DATA_OUT(dout), .DATA_OE(doe),
    .CAP_DATA(cdata), .CAP_VALID(cvalid));
  cable_target_model #(.NCH(NCH)) u_target (.CABLE_CLK(cable),
    .RSTN(rstn), .DRV(dout), .DRV_EN(doe), .PIN_OUT(cap_pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Count ticks, cable and coax highs, capture strobes over n cycles
  task automatic run(input int n);
    k = 0;
    h = 0;
    v = 0;
    c = 0;
    repeat (n) begin
      cyc(1);
      k += int'(tick === 1'b1);
      h += int'(cable === 1'b1);
      v += int'(cvalid === 1'b1);
      c += int'(coax === 1'b1);
    end
  endtask : run
  task automatic finish_test;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  // Clock and a slow square wave for the clock inputs
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    ph <= ph + 2'h1;
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test;
  end
  // Main sequence
  initial begin
    {rstn, gen_valid, gen_data, gen_en, cap_edge} = '0;
    cfg = '0;
    cfg.offset_large = 1'b1;
    cfg.divisor = 23'h000002;
    repeat (20) @(posedge clk);
    #1;
    chk(off_large, 1);
    chk(doe, 0);
    chk({launch, exp_dly, locked}, 0);
    rstn = 1;
    foreach (dv[i]) begin
      cfg.divisor = (i == 0) ? 23'h000001 : 23'(i + 1 + (i == 3));
      cyc(6);
      run(120);
      chk(k, 120 / ((i == 0) ? 2 : i + 1 + (i == 3)));
    end
    gen_data = PAT;
    gen_en = ENS;
    gen_valid = 1;
    cyc(12);
    chk(dout, PAT);
    chk(doe, ENS);
    gen_valid = 0;
    gen_data = ~PAT;
    gen_en = '1;
    run(12);
    chk({dout, doe}, {PAT, ENS});
    chk(h != 0, 1);
    cfg.src = SRC_EXT_IN;
    cyc(4);
    run(120);
    chk(k, 30);
    chk(serr, 0);
    cfg.pll_ref = REF_EXT_IN;
    cyc(3);
    chk(serr, 1);
    cfg.pll_ref = REF_NONE;
    cfg.src = SRC_STROBE;
    cyc(3);
    chk(serr, 1);
    cfg.acquiring = 1;
    for (int e = 0; e < 3; e++) begin
      cap_edge = {NCH{2'(e)}};
      cyc(4);
      run(120);
      chk(k, 30);
      chk(serr, 0);
      chk(h, 0);
      chk(c, 0);
      chk(v != 0, 1);
      chk(cdata, cap_pin);
    end
    cfg.src = SRC_ONBOARD;
    cfg.gen_delay = 8'h80;
    cfg.export_delay = 8'h40;
    foreach (dv[i]) begin
      cfg.divisor = 23'(dv[i]);
      cyc(3);
      chk(gen_dly, eg[i]);
      chk(exp_dly, ee[i]);
    end
    cfg.pll_ref = REF_TRIGGER_BUS;
    cfg.coax = COAX_REFERENCE;
    cyc(LOCKN + 10);
    chk(locked, 1);
    run(40);
    chk(c, 20);
    cfg.pll_ref = REF_NONE;
    cyc(4);
    run(8);
    chk(locked, 0);
    chk(c, 0);
    for (int e = 0; e < 3; e++) begin
      cfg.gen_edge = edge_e'(e);
      cyc(2);
      chk(launch, e);
    end
    cfg.phase = 27'h0000ABC;
    cfg.offset_large = 0;
    cyc(2);
    chk(phase_adj, 27'h0000ABC);
    chk(off_large, 0);
    finish_test;
  end
endmodule : sample_clock_routing_tb

bind sample_clock_routing sample_clock_routing_properties #(.NCH(NCH))
  u_props (.CLK(CLK), .RSTN(RSTN), .CFG(CFG), .SAMPLE_TICK(SAMPLE_TICK),
  .CABLE_CLOCK_OUTPUT(CABLE_CLOCK_OUTPUT),
  .COAX_CLOCK_OUTPUT(COAX_CLOCK_OUTPUT), .PLL_LOCKED(PLL_LOCKED),
  .SRC_ERROR(SRC_ERROR), .EXPORT_OFFSET_LARGE(EXPORT_OFFSET_LARGE),
  .EXPORT_DELAY(EXPORT_DELAY), .GEN_DATA_DELAY(GEN_DATA_DELAY),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
